/* design/adcct_sequencer.sv */
/*
 * Conversion timing sequencer of a 10-bit successive approximation converter:
 * sample phase, ten resolution steps, four equalizing steps, result transfer.
 * Assumes the analog core answers each trial code with a comparator level on the same clock,
 * and that the control register and start pulse come from logic on clk_sys.
 */
`timescale 1ns/1ps
`include "adcct_map.svh"

// Functional notes
// - A conversion opens with a sample phase of two sample-clock periods.
// - Then ten successive approximation steps resolve one result bit each.
// - Then four equalizing steps, each one conversion-clock period long.
// - Total time is 14 conversion clocks, 2 sample clocks, 4 half periods.
// - Bits 15:14 select conversion clock, bits 13:12 select sample clock.
// - Conversion clock codes 00, 10, 11 give 24, 96, 48 half periods.
// - Sample clock codes 00 to 11 give 1, 2, 4, 8 conversion clocks.
// - All phases count in half periods of the CPU clock; the step timer counts whole clk_sys clocks, two half periods each.
// - Operations may occur on both CPU clock edges; every register here switches on the rising edge of clk_sys only.
// - Clock mode is taken from three strap inputs held during reset.
module adcct_sequencer #(
	parameter int RES_W = `ADCCT_RES_BITS,
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control from the CPU side
	input wire logic [15:0] converter_control_reg,
	input wire logic startConv,
	// Clock mode straps from pins
	input wire logic [2:0] clock_mode_straps,
	output logic [2:0] clockModeSel,
	// Analog core
	output logic samplePhase,
	output logic convertPhase,
	output logic equalizePhase,
	output logic [RES_W-1:0] trialCode,
	input wire logic compareHigh,
	// Result
	output logic busy,
	output logic resultLoad,
	output logic [RES_W-1:0] resultValue
);
	adcct_pkg::adcct_state_t state_r;
	adcct_pkg::adcct_state_t state_nxt;
	logic [1:0] ctcSel_r;
	logic [1:0] stcSel_r;
	logic [4:0] stepCnt_r;
	logic [4:0] stepCnt_nxt;
	logic [RES_W-1:0] sar_r;
	logic [3:0] bitIdx_r;
	logic [CNT_W-1:0] periodNxt;
	logic timerRun;
	logic tick;
	logic [2:0] strapSync1_r;
	logic [2:0] strapSync2_r;
	logic strapTaken_r;

	// Conversion clock length in clocks; one clock is two half periods
	function automatic logic [CNT_W-1:0] convClkCycles(input logic [1:0] sel);
		unique case (sel)
			2'b10: convClkCycles = CNT_W'(`ADCCT_CCLK_10_CYC);
			2'b11: convClkCycles = CNT_W'(`ADCCT_CCLK_11_CYC);
			// Reserved 01 is never written; it falls back to the fastest clock
			default: convClkCycles = CNT_W'(`ADCCT_CCLK_00_CYC);
		endcase
	endfunction : convClkCycles

	// Sample phase length in conversion-clock steps: two sample clocks
	function automatic logic [4:0] sampleSteps(input logic [1:0] sel);
		sampleSteps = 5'(`ADCCT_SAMPLE_SC) << sel;
	endfunction : sampleSteps

	// Fields read live while idle so the first step already has its length
	logic [1:0] ctcLive;
	logic [1:0] stcLive;
	assign ctcLive = converter_control_reg[`ADCCT_CTC_MSB:`ADCCT_CTC_LSB];
	assign stcLive = converter_control_reg[`ADCCT_STC_MSB:`ADCCT_STC_LSB];

	// Phase sequencing
	always_comb
	begin
		state_nxt = state_r;
		stepCnt_nxt = stepCnt_r;
		unique case (state_r)
			adcct_pkg::ST_IDLE:
			begin
				if (startConv)
				begin
					state_nxt = adcct_pkg::ST_SAMPLE;
					stepCnt_nxt = sampleSteps(stcLive) - 5'h1;
				end
			end
			adcct_pkg::ST_SAMPLE:
			begin
				if (tick)
				begin
					if (stepCnt_r == 5'h0)
					begin
						state_nxt = adcct_pkg::ST_CONVERT;
						stepCnt_nxt = 5'(`ADCCT_RES_BITS - 1);
					end
					else
					begin
						stepCnt_nxt = stepCnt_r - 5'h1;
					end
				end
			end
			adcct_pkg::ST_CONVERT:
			begin
				if (tick)
				begin
					if (stepCnt_r == 5'h0)
					begin
						state_nxt = adcct_pkg::ST_EQUALIZE;
						stepCnt_nxt = 5'(`ADCCT_EQ_STEPS - 1);
					end
					else
					begin
						stepCnt_nxt = stepCnt_r - 5'h1;
					end
				end
			end
			adcct_pkg::ST_EQUALIZE:
			begin
				if (tick)
				begin
					if (stepCnt_r == 5'h0)
					begin
						state_nxt = adcct_pkg::ST_TRANSFER;
					end
					else
					begin
						stepCnt_nxt = stepCnt_r - 5'h1;
					end
				end
			end
			adcct_pkg::ST_TRANSFER:
			begin
				if (tick)
				begin
					state_nxt = adcct_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = adcct_pkg::ST_IDLE;
			end
		endcase
	end

	// Length of the step that follows: transfer takes four half periods
	always_comb
	begin
		if (state_nxt == adcct_pkg::ST_TRANSFER)
		begin
			periodNxt = CNT_W'(`ADCCT_XFER_CYC);
		end
		else if (state_r == adcct_pkg::ST_IDLE)
		begin
			periodNxt = convClkCycles(ctcLive);
		end
		else
		begin
			periodNxt = convClkCycles(ctcSel_r);
		end
	end

	assign timerRun = (state_r != adcct_pkg::ST_IDLE);

	adcct_step_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(timerRun),
		.period(periodNxt),
		.tick(tick)
	);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_r <= adcct_pkg::ST_IDLE;
			stepCnt_r <= 5'h0;
		end
		else
		begin
			state_r <= state_nxt;
			stepCnt_r <= stepCnt_nxt;
		end
	end

	// Fields frozen for the whole conversion; rewrites take effect on the next start
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctcSel_r <= 2'h0;
			stcSel_r <= 2'h0;
		end
		else if (state_r == adcct_pkg::ST_IDLE && startConv)
		begin
			ctcSel_r <= ctcLive;
			stcSel_r <= stcLive;
		end
	end

	// Successive approximation: trial bit kept when the input is at or above the trial code
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sar_r <= '0;
			bitIdx_r <= 4'h0;
		end
		else if (state_r == adcct_pkg::ST_SAMPLE && state_nxt == adcct_pkg::ST_CONVERT)
		begin
			sar_r <= RES_W'(1) << (RES_W - 1);
			bitIdx_r <= 4'(RES_W - 1);
		end
		else if (state_r == adcct_pkg::ST_CONVERT && tick)
		begin
			sar_r[bitIdx_r] <= compareHigh;
			if (bitIdx_r != 4'h0)
			begin
				sar_r[bitIdx_r - 4'h1] <= 1'b1;
				bitIdx_r <= bitIdx_r - 4'h1;
			end
		end
	end

	// Result register written on the last clock of the transfer
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			resultValue <= '0;
			resultLoad <= 1'b0;
		end
		else
		begin
			resultLoad <= (state_r == adcct_pkg::ST_TRANSFER) && tick;
			if ((state_r == adcct_pkg::ST_TRANSFER) && tick)
			begin
				resultValue <= sar_r;
			end
		end
	end

	// Strap pins are asynchronous: two flops, no reset so they follow the pins during reset
	always_ff @(posedge clk_sys)
	begin
		strapSync1_r <= clock_mode_straps;
		strapSync2_r <= strapSync1_r;
	end

	// Mode captured once, on the first edge after reset release
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			clockModeSel <= `ADCCT_STRAP_RESET;
			strapTaken_r <= 1'b0;
		end
		else if (!strapTaken_r)
		begin
			clockModeSel <= strapSync2_r;
			strapTaken_r <= 1'b1;
		end
	end

	assign samplePhase = (state_r == adcct_pkg::ST_SAMPLE);
	assign convertPhase = (state_r == adcct_pkg::ST_CONVERT);
	assign equalizePhase = (state_r == adcct_pkg::ST_EQUALIZE);
	assign busy = (state_r != adcct_pkg::ST_IDLE);
	assign trialCode = sar_r;
endmodule : adcct_sequencer

/* common/adcct_map.svh */
/*
 * Constants of the converter timing sequencer: field positions, reset values and timing counts.
 * Assumes one system clock whose half period is the converter timing unit.
 */
`ifndef ADCCT_MAP_SVH
`define ADCCT_MAP_SVH

// Field positions in the converter control register
`define ADCCT_CTC_MSB 15
`define ADCCT_CTC_LSB 14
`define ADCCT_STC_MSB 13
`define ADCCT_STC_LSB 12

// Clock: 40 MHz, and one clock period holds two half periods
`define ADCCT_CLK_PERIOD_PS 25000
`define ADCCT_HALF_PERIOD_PS (`ADCCT_CLK_PERIOD_PS / 2)
`define ADCCT_HALF_PER_CLK (`ADCCT_CLK_PERIOD_PS / `ADCCT_HALF_PERIOD_PS)

// Conversion clock period per select code, in half periods and in clocks
`define ADCCT_CCLK_00_HALF 24
`define ADCCT_CCLK_10_HALF 96
`define ADCCT_CCLK_11_HALF 48
`define ADCCT_CCLK_00_CYC (`ADCCT_CCLK_00_HALF / `ADCCT_HALF_PER_CLK)
`define ADCCT_CCLK_10_CYC (`ADCCT_CCLK_10_HALF / `ADCCT_HALF_PER_CLK)
`define ADCCT_CCLK_11_CYC (`ADCCT_CCLK_11_HALF / `ADCCT_HALF_PER_CLK)

// Result transfer time, in half periods and in clocks
`define ADCCT_XFER_HALF 4
`define ADCCT_XFER_CYC (`ADCCT_XFER_HALF / `ADCCT_HALF_PER_CLK)

// Step counts of each phase
`define ADCCT_SAMPLE_SC 2
`define ADCCT_RES_BITS 10
`define ADCCT_EQ_STEPS 4

// Clock mode straps: value held until the first capture after reset
`define ADCCT_STRAP_RESET 3'h7
`endif

/* common/adcct_pkg.sv */
/*
 * Types of the converter timing sequencer.
 * Assumes adcct_map.svh supplies all numeric constants.
 */
package adcct_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_CONVERT = 3'b010,
		ST_EQUALIZE = 3'b011,
		ST_TRANSFER = 3'b100
	} adcct_state_t;
endpackage : adcct_pkg

/* design/adcct_step_timer.sv */
/*
 * Auto-reloading step timer: counts a period of clocks and ticks on its last clock.
 * Assumes the period input already holds the length of the step that follows a tick.
 */
`timescale 1ns/1ps
module adcct_step_timer #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [CNT_W-1:0] period,
	// Status
	output logic tick
);
	logic [CNT_W-1:0] count_r;

	// Tick on the last clock of a step, so a step of N clocks really lasts N clocks
	assign tick = run && (count_r == CNT_W'(1));

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			count_r <= '0;
		end
		else if (!run || tick)
		begin
			count_r <= period;
		end
		else
		begin
			count_r <= count_r - CNT_W'(1);
		end
	end
endmodule : adcct_step_timer

/* testbench/adcct_analog_model.sv */
/* Behavioural analog core facing the sequencer.
   Assumes the bench supplies the input level on clk_sys. */
`timescale 1ns/1ps
module adcct_analog_model (
	// Clock and level
	input wire logic clk_sys,
	input wire logic [9:0] analogIn,
	// Sequencer side
	input wire logic samplePhase,
	input wire logic convertPhase,
	input wire logic [9:0] trialCode,
	output logic compareHigh
);
	logic [9:0] heldLevel_r;
	// Later input changes must not reach the result
	always_ff @(posedge clk_sys)
		if (samplePhase)
			heldLevel_r <= analogIn;
	// Off the resolution steps the level means nothing, so show the inverse
	assign compareHigh = convertPhase ? (heldLevel_r >= trialCode)
		: !(heldLevel_r >= trialCode);
endmodule : adcct_analog_model

/* testbench/adcct_seq_monitor.sv */
/* Port checker of the conversion sequencer.
   Assumes the sequencer ports only. */
`timescale 1ns/1ps
module adcct_seq_monitor #(
	parameter int RES_W = 10,
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic [15:0] converter_control_reg,
	input wire logic startConv,
	input wire logic [2:0] clock_mode_straps,
	input wire logic [2:0] clockModeSel,
	// Core and result
	input wire logic samplePhase,
	input wire logic convertPhase,
	input wire logic equalizePhase,
	input wire logic [RES_W-1:0] trialCode,
	input wire logic compareHigh,
	input wire logic busy,
	input wire logic resultLoad,
	input wire logic [RES_W-1:0] resultValue
);
	int c;
	int m;
	int cnt;
	// Own copy of the fields taken at start, so rewrites cannot mislead
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			c <= 12;
			m <= 1;
		end
		else if (startConv && !busy)
		begin
			cnt <= 0;
			c <= (converter_control_reg[15:14] == 2'b10) ? 48
				: (converter_control_reg[15:14] == 2'b11) ? 24 : 12;
			m <= 1 << converter_control_reg[13:12];
		end
		else if (busy)
			cnt <= cnt + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence loadPulse;
		resultLoad ##1 !resultLoad;
	endsequence
	sequence convOpen;
		convertPhase && trialCode == 10'h200;
	endsequence
	start_sample_a: assert property (startConv && !busy |=> busy && samplePhase)
		else $error("sample phase missing after start");
	sample_len_a: assert property ($fell(samplePhase) |-> cnt == 2*m*c)
		else $error("sample phase length wrong");
	trial_open_a: assert property ($fell(samplePhase) |-> convOpen)
		else $error("resolution does not open at top bit");
	convert_len_a: assert property ($fell(convertPhase) |-> cnt == (2*m+10)*c && equalizePhase)
		else $error("resolution length wrong");
	equal_len_a: assert property ($fell(equalizePhase) |-> cnt == (2*m+14)*c)
		else $error("equalizing length wrong");
	total_time_a: assert property ($fell(busy) |-> cnt == (2*m+14)*c+2)
		else $error("conversion time wrong");
	load_pulse_a: assert property ($fell(busy) |-> loadPulse)
		else $error("result load pulse wrong");
	result_hold_a: assert property (!resultLoad |-> $stable(resultValue))
		else $error("result changed without load");
	phase_excl_a: assert property ($onehot0({samplePhase, convertPhase, equalizePhase}))
		else $error("phases overlap");
	mode_hold_a: assert property ($past(!rst, 2) |-> $stable(clockModeSel))
		else $error("clock mode changed after reset");
endmodule : adcct_seq_monitor
bind adcct_sequencer adcct_seq_monitor #(.RES_W(RES_W), .CNT_W(CNT_W)) adcct_seq_monitor_inst (
	.clk_sys, .rst, .converter_control_reg, .startConv, .clock_mode_straps, .clockModeSel,
	.samplePhase, .convertPhase, .equalizePhase, .trialCode, .compareHigh, .busy,
	.resultLoad, .resultValue);

/* testbench/adc_conversion_timing_tb.sv */
/* Self-checking bench of the conversion sequencer with an analog core model.
   Assumes the sequencer, the core model and the checker. */
`timescale 1ns/1ps
`include "adcct_map.svh"
module adc_conversion_timing_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [15:0] converter_control_reg = 16'h0000;
	logic startConv = 1'b0;
	logic [2:0] clock_mode_straps = 3'h5;
	logic [9:0] analogIn = 10'h000;
	logic [2:0] clockModeSel;
	logic samplePhase, convertPhase, equalizePhase, compareHigh, busy, resultLoad;
	logic [9:0] trialCode, resultValue;
	int err_count = 0;
	int checks = 0;
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	adcct_sequencer adcct_sequencer_inst (.clk_sys, .rst, .converter_control_reg, .startConv,
		.clock_mode_straps, .clockModeSel, .samplePhase, .convertPhase, .equalizePhase,
		.trialCode, .compareHigh, .busy, .resultLoad, .resultValue);
	adcct_analog_model adcct_analog_model_inst (.clk_sys, .analogIn, .samplePhase,
		.convertPhase, .trialCode, .compareHigh);
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_cnt(input int got, input int exp);
		checks++;
		if (got != exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	// A second start and a field rewrite during busy must both be ignored
	task automatic run_conv(input logic [1:0] ctc, input logic [1:0] stc, input logic [9:0] vin);
		int convHalf;
		int n;
		int s;
		convHalf = (ctc == 2'b10) ? `ADCCT_CCLK_10_HALF : (ctc == 2'b11) ? `ADCCT_CCLK_11_HALF
			: `ADCCT_CCLK_00_HALF;
		n = 0;
		s = 0;
		converter_control_reg = {ctc, stc, 12'h000};
		analogIn = vin;
		startConv = 1'b1;
		@(negedge clk_sys);
		converter_control_reg = 16'h3000;
		while (busy === 1'b1 && n < 4000)
		begin
			n++;
			s += (samplePhase === 1'b1);
			@(negedge clk_sys);
			// Start held over a busy edge as a refused request, then dropped once only
			if (n == 1)
			begin
				startConv = 1'b0;
			end
		end
		chk_cnt(n, (14*convHalf + 2*(convHalf << stc) + `ADCCT_XFER_HALF) / 2);
		chk_cnt(s, convHalf << stc);
		chk_val(resultLoad, 1'b1);
		chk_val(resultValue, vin);
	endtask : run_conv
	task automatic scen_straps();
		repeat (2) @(negedge clk_sys);
		chk_val(clockModeSel, 3'h5);
		clock_mode_straps = 3'h2;
		repeat (4) @(negedge clk_sys);
		chk_val(clockModeSel, 3'h5);
	endtask : scen_straps
	task automatic scen_fast();
		run_conv(2'b00, 2'b00, 10'h2a5);
	endtask : scen_fast
	// Back to back: each start lands in the previous load cycle
	task automatic scen_codes();
		// Reserved conversion clock code 01 is never driven
		logic [13:0] tbl [4] = '{{4'b1101, 10'h3ff}, {4'b1010, 10'h000},
			{4'b0011, 10'h155}, {4'b1011, 10'h200}};
		foreach (tbl[i])
			run_conv(tbl[i][13:12], tbl[i][11:10], tbl[i][9:0]);
	endtask : scen_codes
	initial
	begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		scen_straps();
		scen_fast();
		scen_codes();
		complete_run();
	end
	initial
	begin
		repeat (10000) @(posedge clk_sys);
		err_count++;
		complete_run();
	end
endmodule : adc_conversion_timing_tb
